// ### cshc_framer.sv
`timescale 1ns/100ps
// Overview of operation
// - Inputs sampled and outputs changed on each serial clock rising edge.
// - Each transfer is header, data, then optional tail, in that order.
// - Header and tail pass on; each device strips its own data.
// - Per-device data is selected by stream position alone.
// - Sync pattern is searched for while load strobe is low.
// - Header is 24 bits: 8 sync, 6 command, 10 fault count.
// - After sync, load strobe rising edge aligns internal strobe timing.
// - Command codes select PWM, calibration, global or configuration load.
// - Command decides captured bit count and destination storage.
// - A faulty device adds one to the forwarded fault count.
// - Low command bit zero counts overtemperature, one counts open LED.
// - Config bit 4 selects global quarter mode, reset zero.
// - Config bit 3 enables PWM outputs, reset zero, intensities untouched.
// - Config bit 2 pulses a counter reset and self-clears.
// - Config bit 1 enables the interface timeout, reset zero.
// - Config bit 0 enables multiplexing, reset zero.
// - Own data kept; new header starts data length plus one clocks after header start.
// - Later data and tail forwarded one serial clock late.
// - Non-PWM commands carry 24 bits per device, MSB first.

// ----------------------------------------
// Captured word buffer
// ----------------------------------------
module cshc_fifo #(
  parameter int WIDTH = 27,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  // Drain side
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [CW-1:0]    count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [CW-1:0]    next_count;
  logic             next_in_ready;
  logic             next_out_valid;
  logic [WIDTH-1:0] next_out_data;
  logic             push;
  logic             pop;

  // Output stage is a register so the drain side sees flop outputs
  always_comb
  begin
    push           = in_valid_i & in_ready_o;
    pop            = (~out_valid_o | out_ready_i) & (count != '0);
    next_wr_ptr    = push ? wr_ptr + AW'(1) : wr_ptr;
    next_rd_ptr    = pop ? rd_ptr + AW'(1) : rd_ptr;
    next_count     = count + CW'(push) - CW'(pop);
    next_out_valid = pop | (out_valid_o & ~out_ready_i);
    next_out_data  = pop ? mem[rd_ptr] : out_data_o;
    // Output register counts toward depth, else DEPTH+1 words fit
    next_in_ready  = (next_count + CW'(next_out_valid)) != CW'(DEPTH);
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr      <= '0;
      rd_ptr      <= '0;
      count       <= '0;
      in_ready_o  <= 1'b1;
      out_valid_o <= 1'b0;
      out_data_o  <= '0;
    end
    else
    begin
      wr_ptr      <= next_wr_ptr;
      rd_ptr      <= next_rd_ptr;
      count       <= next_count;
      in_ready_o  <= next_in_ready;
      out_valid_o <= next_out_valid;
      out_data_o  <= next_out_data;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end
endmodule

// ----------------------------------------
// Serial header framer and config decoder
// ----------------------------------------
module cshc_framer
  import cshc_pkg::*;
#(
  parameter bit PWM14_VARIANT = 1'b0
) (
  // Clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  // Serial link in
  input  wire logic       serial_clock_in_i,
  input  wire logic       serial_data_in_i,
  input  wire logic       load_strobe_in_i,
  // Serial link out
  output logic            serial_clock_out_o,
  output logic            serial_data_out_o,
  output logic            load_strobe_out_o,
  // Fault sense
  input  wire logic       fault_overtemp_i,
  input  wire logic       fault_open_led_i,
  // Configuration byte
  output logic            global_quarter_select_o,
  output logic            pwm_enable_o,
  output logic            counter_sync_reset_o,
  output logic            interface_timeout_enable_o,
  output logic            multiplex_enable_o,
  // Captured data
  output logic            cap_valid_o,
  output cshc_word_t      cap_word_o,
  input  wire logic       cap_ready_i,
  output logic            cap_space_o,
  output logic            cap_overflow_o
);
  logic [2:0]  sync1;
  logic [2:0]  sync2;
  logic [2:0]  sync3;
  logic [2:0]  lvl;
  logic [2:0]  next_lvl;
  logic        tick;
  logic        din;
  logic        lin;
  logic        rise;

  cshc_state_t state;
  cshc_state_t next_state;
  logic [10:0] pos;
  logic [10:0] next_pos;
  logic [7:0]  hist;
  logic [7:0]  next_hist;
  logic [5:0]  cmd_sh;
  logic [5:0]  next_cmd_sh;
  logic [9:0]  cnt_sh;
  logic [9:0]  next_cnt_sh;
  logic [23:0] word_sh;
  logic [23:0] next_word_sh;
  logic [4:0]  wcnt;
  logic [4:0]  next_wcnt;
  logic [23:0] hdr_sh;
  logic [23:0] next_hdr_sh;
  logic [4:0]  emit_cnt;
  logic [4:0]  next_emit_cnt;
  logic        load_seen;
  logic        next_load_seen;
  logic        din_prev;
  logic        next_din_prev;
  logic        load_tick;
  logic        next_load_tick;
  logic        next_sdo;
  logic        next_slo;
  logic [7:0]  cfg;
  logic [7:0]  next_cfg;
  logic        next_counter_sync_reset;
  logic        next_ovf;
  logic        cfg_apply;
  logic        fault_hit;
  logic [10:0] data_len;
  logic [23:0] full_word;
  logic [7:0]  vote;
  logic        push;
  cshc_word_t  push_word;
  logic        fifo_ready;

  // ----------------------------------------
  // Input synchronisers, 2nd and 3rd agree
  // ----------------------------------------
  always_comb
  begin
    next_lvl = lvl;
    for (int i = 0; i < 3; i++)
    begin
      if (sync2[i] == sync3[i])
      begin
        next_lvl[i] = sync3[i];
      end
    end
    tick = next_lvl[SYNC_CLK] & ~lvl[SYNC_CLK];
    din  = next_lvl[SYNC_DATA];
    lin  = next_lvl[SYNC_LOAD];
    rise = lin & ~load_tick;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      lvl   <= '0;
    end
    else
    begin
      sync1 <= {load_strobe_in_i, serial_data_in_i, serial_clock_in_i};
      sync2 <= sync1;
      sync3 <= sync2;
      lvl   <= next_lvl;
    end
  end

  // ----------------------------------------
  // Frame decoding and header regeneration
  // ----------------------------------------
  always_comb
  begin
    unique case (cshc_cmd_t'(cmd_sh[1:0]))
      CMD_PWM:
      begin
        if (PWM14_VARIANT)
          data_len = cfg[CFG_MUX_BIT] ? LEN_PWM14_MUX : LEN_PWM14;
        else
          data_len = cfg[CFG_MUX_BIT] ? LEN_PWM12_MUX : LEN_PWM12;
      end
      CMD_CAL, CMD_GLOBAL, CMD_CONFIG:
      begin
        data_len = LEN_WORD;
      end
    endcase
    fault_hit = cmd_sh[0] ? fault_open_led_i : fault_overtemp_i;
    full_word = {word_sh[22:0], din};
    // Bitwise vote over the three repeated copies; upper bits dropped
    vote = (full_word[23:16] & full_word[15:8]) | (full_word[23:16] & full_word[7:0])
         | (full_word[15:8] & full_word[7:0]);
    next_state     = state;
    next_pos       = pos;
    next_hist      = hist;
    next_cmd_sh    = cmd_sh;
    next_cnt_sh    = cnt_sh;
    next_word_sh   = word_sh;
    next_wcnt      = wcnt;
    next_hdr_sh    = hdr_sh;
    next_emit_cnt  = emit_cnt;
    next_load_seen = load_seen;
    next_din_prev  = din_prev;
    next_load_tick = load_tick;
    next_sdo       = serial_data_out_o;
    next_slo       = load_strobe_out_o;
    next_cfg       = cfg;
    next_counter_sync_reset      = 1'b0;
    next_ovf       = cap_overflow_o;
    cfg_apply      = 1'b0;
    push           = 1'b0;
    push_word      = '{cmd: cshc_cmd_t'(cmd_sh[1:0]), last: 1'b0, data: full_word};
    if (tick)
    begin
      next_din_prev  = din;
      next_load_tick = lin;
      next_hist      = {hist[6:0], din};
      next_pos       = pos + 11'h001;
      if (emit_cnt != '0)
      begin
        next_sdo      = hdr_sh[23];
        next_hdr_sh   = {hdr_sh[22:0], 1'b0};
        next_emit_cnt = emit_cnt - 5'h01;
        if (emit_cnt == EMIT_CMD_LEFT)
        begin
          next_slo = 1'b1;
        end
      end
      else if (state == ST_FWD)
      begin
        next_sdo = din_prev;
        next_slo = load_tick;
      end
      else
      begin
        next_sdo = 1'b0;
        next_slo = 1'b0;
      end
      if (state == ST_DATA && pos == data_len)
      begin
        next_hdr_sh   = {SYNC_PATTERN, cmd_sh, cnt_sh + 10'(fault_hit)};
        next_emit_cnt = EMIT_BITS;
      end
      unique case (state)
        ST_HUNT:
        begin
          if (!load_tick && next_hist == SYNC_PATTERN)
          begin
            next_state     = ST_CMD;
            next_pos       = POS_CMD_FIRST;
            next_load_seen = rise;
          end
        end
        ST_CMD:
        begin
          next_cmd_sh = {cmd_sh[4:0], din};
          if (rise && pos <= POS_LOAD_LAST)
          begin
            next_load_seen = 1'b1;
          end
          if (pos == POS_LOAD_LAST && !(load_seen | rise))
          begin
            next_state = ST_HUNT;
          end
          else if (pos == POS_CMD_LAST)
          begin
            if (next_cmd_sh[5:4] == next_cmd_sh[3:2] && next_cmd_sh[3:2] == next_cmd_sh[1:0])
              next_state = ST_CNT;
            else
              next_state = ST_HUNT;
          end
        end
        ST_CNT:
        begin
          next_cnt_sh = {cnt_sh[8:0], din};
          if (pos == POS_HDR_LAST)
          begin
            next_state = ST_DATA;
            next_wcnt  = '0;
          end
        end
        ST_DATA:
        begin
          next_word_sh = full_word;
          next_wcnt    = wcnt + 5'h01;
          if (wcnt == WORD_LAST)
          begin
            next_wcnt = '0;
            push      = 1'b1;
          end
          if (pos == data_len + POS_HDR_LAST)
          begin
            push_word.last = 1'b1;
            next_state     = ST_FWD;
            cfg_apply      = cmd_sh[1:0] == CMD_CONFIG;
          end
        end
        ST_FWD:
        begin
          if (!lin)
          begin
            next_state = ST_HUNT;
          end
        end
        default:
        begin
          next_state = ST_HUNT;
        end
      endcase
    end
    if (push && !fifo_ready)
    begin
      next_ovf = 1'b1;
    end
    if (cfg_apply)
    begin
      next_cfg[CFG_GLOBAL_QUARTER_SELECT_BIT] = vote[CFG_GLOBAL_QUARTER_SELECT_BIT];
      next_cfg[CFG_PWM_BIT]  = vote[CFG_PWM_BIT];
      next_counter_sync_reset              = vote[CFG_COUNTER_SYNC_RESET_BIT];
      next_cfg[CFG_INTERFACE_TIMEOUT_ENABLE_BIT] = vote[CFG_INTERFACE_TIMEOUT_ENABLE_BIT];
      next_cfg[CFG_MUX_BIT]  = vote[CFG_MUX_BIT];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state                <= ST_HUNT;
      pos                  <= '0;
      hist                 <= '0;
      cmd_sh               <= '0;
      cnt_sh               <= '0;
      word_sh              <= '0;
      wcnt                 <= '0;
      hdr_sh               <= '0;
      emit_cnt             <= '0;
      load_seen            <= 1'b0;
      din_prev             <= 1'b0;
      load_tick            <= 1'b0;
      serial_clock_out_o   <= 1'b0;
      serial_data_out_o    <= 1'b0;
      load_strobe_out_o    <= 1'b0;
      cfg                  <= CFG_RESET;
      counter_sync_reset_o <= 1'b0;
      cap_overflow_o       <= 1'b0;
    end
    else
    begin
      state                <= next_state;
      pos                  <= next_pos;
      hist                 <= next_hist;
      cmd_sh               <= next_cmd_sh;
      cnt_sh               <= next_cnt_sh;
      word_sh              <= next_word_sh;
      wcnt                 <= next_wcnt;
      hdr_sh               <= next_hdr_sh;
      emit_cnt             <= next_emit_cnt;
      load_seen            <= next_load_seen;
      din_prev             <= next_din_prev;
      load_tick            <= next_load_tick;
      serial_clock_out_o   <= next_lvl[SYNC_CLK];
      serial_data_out_o    <= next_sdo;
      load_strobe_out_o    <= next_slo;
      cfg                  <= next_cfg;
      counter_sync_reset_o <= next_counter_sync_reset;
      cap_overflow_o       <= next_ovf;
    end
  end

  assign global_quarter_select_o    = cfg[CFG_GLOBAL_QUARTER_SELECT_BIT];
  assign pwm_enable_o               = cfg[CFG_PWM_BIT];
  assign interface_timeout_enable_o = cfg[CFG_INTERFACE_TIMEOUT_ENABLE_BIT];
  assign multiplex_enable_o         = cfg[CFG_MUX_BIT];

  // Full buffer drops the word and raises the sticky overflow flag
  cshc_fifo #(
    .WIDTH ($bits(cshc_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i),
    .in_valid_i  (push),
    .in_data_i   (push_word),
    .in_ready_o  (fifo_ready),
    .out_valid_o (cap_valid_o),
    .out_data_o  (cap_word_o),
    .out_ready_i (cap_ready_i)
  );
  assign cap_space_o = fifo_ready;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  clk_out_follow_a: assert property (tick |=> serial_clock_out_o)
    else $error("clock out missed rising edge");
  hunt_load_low_a: assert property (state == ST_HUNT && next_state == ST_CMD |-> !load_tick)
    else $error("sync taken with load high");
  cmd_triple_a: assert property (state == ST_CNT && tick |-> cmd_sh[5:4] == cmd_sh[1:0])
    else $error("command not repeated");
  emit_start_a: assert property (emit_cnt == '0 ##1 emit_cnt == EMIT_BITS |-> pos == data_len + 11'h001)
    else $error("header regenerated at wrong position");
  load_out_rise_a: assert property ($rose(load_strobe_out_o) && state != ST_FWD |-> emit_cnt == 5'h0F)
    else $error("load out not at first command bit");
  fwd_delay_a: assert property (tick && state == ST_FWD && emit_cnt == '0
    |=> serial_data_out_o == $past(din_prev))
    else $error("forwarded bit not one clock late");
  fault_add_a: assert property (tick && state == ST_DATA && pos == data_len && fault_hit
    |=> hdr_sh[9:0] == $past(cnt_sh) + 10'h001)
    else $error("fault count not incremented");
  counter_sync_reset_pulse_a: assert property (counter_sync_reset_o |=> !counter_sync_reset_o)
    else $error("counter reset not self clearing");
  cfg_hold_a: assert property (!cfg_apply |=> $stable(cfg))
    else $error("config changed without a config load");
  word_push_a: assert property (push |-> state == ST_DATA && tick)
    else $error("capture outside data segment");

  cfg_load_c: cover property (cfg_apply ##1 pwm_enable_o);
  pwm_frame_c: cover property (push && push_word.last && push_word.cmd == CMD_PWM);
  emit_done_c: cover property (emit_cnt == 5'h01 ##[1:20] state == ST_FWD);
  overflow_c: cover property ($rose(cap_overflow_o));
endmodule

// ### cshc_pkg.sv
package cshc_pkg;

  // ----------------------------------------
  // Header layout
  // ----------------------------------------
  localparam logic [7:0]  SYNC_PATTERN = 8'hE8;
  localparam logic [10:0] POS_CMD_FIRST = 11'h008;
  localparam logic [10:0] POS_LOAD_LAST = 11'h009;
  localparam logic [10:0] POS_CMD_LAST  = 11'h00D;
  localparam logic [10:0] POS_HDR_LAST  = 11'h017;
  localparam logic [10:0] HDR_BITS      = 11'h018;
  localparam logic [4:0]  EMIT_BITS     = 5'h18;
  localparam logic [4:0]  EMIT_CMD_LEFT = 5'h10;
  localparam logic [4:0]  WORD_LAST     = 5'h17;

  // ----------------------------------------
  // Data lengths per device
  // ----------------------------------------
  localparam logic [10:0] LEN_WORD      = 11'h018;
  localparam logic [10:0] LEN_PWM12     = 11'h120;
  localparam logic [10:0] LEN_PWM12_MUX = 11'h240;
  localparam logic [10:0] LEN_PWM14     = 11'h150;
  localparam logic [10:0] LEN_PWM14_MUX = 11'h2A0;

  // ----------------------------------------
  // Configuration byte
  // ----------------------------------------
  localparam int         CFG_MUX_BIT  = 0;
  localparam int         CFG_INTERFACE_TIMEOUT_ENABLE_BIT = 1;
  localparam int         CFG_COUNTER_SYNC_RESET_BIT = 2;
  localparam int         CFG_PWM_BIT  = 3;
  localparam int         CFG_GLOBAL_QUARTER_SELECT_BIT = 4;
  localparam logic [7:0] CFG_RESET    = 8'h00;

  localparam int FIFO_DEPTH = 16;
  localparam int SYNC_CLK   = 0;
  localparam int SYNC_DATA  = 1;
  localparam int SYNC_LOAD  = 2;

  typedef enum logic [1:0] {
    CMD_PWM    = 2'b00,
    CMD_CAL    = 2'b01,
    CMD_GLOBAL = 2'b10,
    CMD_CONFIG = 2'b11
  } cshc_cmd_t;

  typedef enum logic [2:0] {
    ST_HUNT = 3'b000,
    ST_CMD  = 3'b001,
    ST_CNT  = 3'b010,
    ST_DATA = 3'b011,
    ST_FWD  = 3'b100
  } cshc_state_t;

  typedef struct packed {
    cshc_cmd_t   cmd;
    logic        last;
    logic [23:0] data;
  } cshc_word_t;

endpackage

// ### cshc_host_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Upstream transmitter model
// ----------------------------------------
module cshc_host_model (
  // Serial link
  output logic serial_clock_o,
  output logic serial_data_o,
  output logic load_strobe_o
);
  // Free-running link clock, phase unrelated to the sys clock
  initial
  begin
    serial_clock_o = 1'b0;
    serial_data_o  = 1'b0;
    load_strobe_o  = 1'b0;
    #7;
    forever #100 serial_clock_o = ~serial_clock_o;
  end

  // Bits change at the falling edge, half a period away from sampling
  task automatic send_frame(input logic [7:0] sync, input logic [5:0] cmdf, input logic data[$],
                            input int load_pos, output logic bits[$]);
    logic [23:0] hdr;
    hdr  = {sync, cmdf, 10'h000};
    bits = {};
    for (int i = 23; i >= 0; i--)
      bits.push_back(hdr[i]);
    bits = {bits, data};
    // Tail of 3 to 10 random bits is forwarded after the new header, which goes out during own data
    for (int i = $urandom_range(10, 3); i > 0; i--)
      bits.push_back(1'($urandom));
    for (int i = 0; i < bits.size(); i++)
    begin
      @(negedge serial_clock_o);
      serial_data_o = bits[i];
      if (i == load_pos)
        load_strobe_o = 1'b1;
    end
    // Load low closes the frame; idle data toggles so it never looks stable
    for (int i = 0; i < 4; i++)
    begin
      @(negedge serial_clock_o);
      load_strobe_o = 1'b0;
      serial_data_o = ~serial_data_o;
    end
  endtask
endmodule

// ### testbench.sv
`timescale 1ns/100ps
module testbench;
  import cshc_pkg::*;
  typedef logic cshc_tb_bits_t[$];

  logic       sys_clk_i = 1'b0;
  logic       rst_n_i   = 1'b0;
  logic       fault_ot  = 1'b0;
  logic       fault_ol  = 1'b0;
  logic       cap_ready = 1'b0;
  logic       drain_en  = 1'b1;
  logic       mon_on    = 1'b0;
  logic       ser_clk, ser_dat, ser_ld, clk_out, dat_out, ld_out;
  logic       global_quarter_select, pwm_en, counter_sync_reset, interface_timeout_enable, multiplex_enable, cap_valid, cap_space, cap_ovf;
  logic [3:0] cfg_exp   = 4'h0;
  cshc_word_t cap_word;
  cshc_word_t capq[$];
  logic       outq[$];
  logic       ldq[$];
  int         error_cnt = 0;
  int         tests_run = 0;
  int         cycles    = 0;
  int         counter_sync_reset_cnt  = 0;
  int         n_counter_sync_reset    = 0;
  int         clk_bad   = 0;

  cshc_host_model i_host (.serial_clock_o(ser_clk), .serial_data_o(ser_dat), .load_strobe_o(ser_ld));

  cshc_framer i_dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
    .serial_clock_in_i(ser_clk), .serial_data_in_i(ser_dat), .load_strobe_in_i(ser_ld),
    .serial_clock_out_o(clk_out), .serial_data_out_o(dat_out), .load_strobe_out_o(ld_out),
    .fault_overtemp_i(fault_ot), .fault_open_led_i(fault_ol),
    .global_quarter_select_o(global_quarter_select), .pwm_enable_o(pwm_en), .counter_sync_reset_o(counter_sync_reset),
    .interface_timeout_enable_o(interface_timeout_enable), .multiplex_enable_o(multiplex_enable),
    .cap_valid_o(cap_valid), .cap_word_o(cap_word), .cap_ready_i(cap_ready),
    .cap_space_o(cap_space), .cap_overflow_o(cap_ovf)
  );

  always #12.5 sys_clk_i = ~sys_clk_i;

  always @(negedge sys_clk_i)
    cap_ready <= drain_en & 1'($urandom);

  always @(posedge sys_clk_i)
  begin
    if (cap_valid && cap_ready)
      capq.push_back(cap_word);
    if (counter_sync_reset)
      counter_sync_reset_cnt++;
    cycles++;
    if (cycles == 60000)
    begin
      error_cnt++;
      $display("ERROR timeout expected end of run seen %0d cycles", cycles);
      summarize();
    end
  end

  // Entry n holds what the outputs showed after link edge n-1
  always @(posedge ser_clk)
    if (mon_on)
    begin
      outq.push_back(dat_out);
      ldq.push_back(ld_out);
      if (clk_out !== 1'b0)
        clk_bad++;
    end

  // Regenerated link clock lags the pin by under half a link period
  always @(negedge ser_clk)
    if (mon_on && clk_out !== 1'b1)
      clk_bad++;

  task automatic check(input string what, input logic [26:0] exp, input logic [26:0] got);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  function automatic cshc_tb_bits_t rnd_bits(input int n);
    cshc_tb_bits_t q;
    q = {};
    for (int i = 0; i < n; i++)
      q.push_back(1'($urandom));
    return q;
  endfunction

  task automatic run_frame(input logic [7:0] sync, input logic [5:0] cmdf, input logic data[$], input int lp);
    logic          bits[$];
    cshc_word_t    expq[$];
    logic [23:0]   hdr;
    logic [23:0]   w;
    logic          e;
    logic          good;
    int            len;
    int            bad;
    good = sync == SYNC_PATTERN && cmdf == {3{cmdf[1:0]}} && lp >= 7 && lp <= 9;
    len  = data.size();
    @(negedge sys_clk_i);
    fault_ot = 1'($urandom);
    fault_ol = 1'($urandom);
    outq = {};
    ldq  = {};
    capq = {};
    clk_bad = 0;
    fork
      i_host.send_frame(sync, cmdf, data, lp, bits);
      begin
        @(negedge ser_clk);
        mon_on = 1'b1;
      end
    join
    mon_on = 1'b0;
    repeat (40) @(negedge sys_clk_i);
    hdr = {SYNC_PATTERN, cmdf, 9'h000, cmdf[0] ? fault_ol : fault_ot};
    bad = 0;
    for (int n = 1; n < outq.size(); n++)
    begin
      e = (!good || n < len + 2 || n >= bits.size() + 2) ? 1'b0
        : (n < len + 26) ? hdr[len + 25 - n] : bits[n - 2];
      if (outq[n] !== e || ldq[n] !== (good && n >= len + 10 && n < bits.size() + 2))
        bad++;
    end
    check("forwarded stream bit errors", 27'h0, 27'(bad));
    check("clock out phase errors", 27'h0, 27'(clk_bad));
    expq = {};
    for (int i = 0; good && i < len / 24; i++)
    begin
      for (int j = 0; j < 24; j++)
        w[23 - j] = bits[24 + 24 * i + j];
      expq.push_back('{cshc_cmd_t'(cmdf[1:0]), i == len / 24 - 1, w});
    end
    if (!drain_en)
    begin
      check("buffer space when full", 27'h0, 27'(cap_space));
      check("overflow flag", 27'h1, 27'(cap_ovf));
      drain_en = 1'b1;
      repeat (200) @(negedge sys_clk_i);
      while (expq.size() > FIFO_DEPTH)
        void'(expq.pop_back());
      check("valid after drain", 27'h0, 27'(cap_valid));
    end
    check("captured word count", 27'(expq.size()), 27'(capq.size()));
    for (int i = 0; i < expq.size(); i++)
      check("captured word", expq[i], capq[i]);
  endtask

  task automatic send_cmd(input logic [1:0] c, input int lp, input logic [7:0] b);
    logic d[$];
    d = rnd_bits(c == 2'b00 ? (cfg_exp[0] ? 576 : 288) : 24);
    // One corrupted copy must lose the bitwise vote
    for (int i = 0; c == 2'b11 && i < 8; i++)
    begin
      d[i]      = b[7 - i];
      d[i + 16] = b[7 - i];
    end
    run_frame(SYNC_PATTERN, {3{c}}, d, lp);
    if (c == 2'b11)
    begin
      n_counter_sync_reset  = n_counter_sync_reset + b[2];
      cfg_exp = {b[4], b[3], b[1], b[0]};
      check("config outputs", 27'(cfg_exp), 27'({global_quarter_select, pwm_en, interface_timeout_enable, multiplex_enable}));
      check("counter reset pulses", 27'(n_counter_sync_reset), 27'(counter_sync_reset_cnt));
    end
    $display("test command %0d load at %0d done", c, lp);
  endtask

  initial
  begin
    void'($urandom(79779));
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    check("config after reset", 27'h0, 27'({global_quarter_select, pwm_en, counter_sync_reset, interface_timeout_enable, multiplex_enable}));
    check("space after reset", 27'h1, 27'(cap_space));
    for (int t = 0; t < 10; t++)
      send_cmd(t < 4 ? 2'(t) : 2'($urandom), $urandom_range(9, 7), 8'($urandom));
    // Bad sync, broken command triple, late load strobe
    for (int i = 0; i < 3; i++)
      run_frame(i == 0 ? 8'hE9 : SYNC_PATTERN, i == 1 ? 6'h37 : 6'h3F, rnd_bits(24), i == 2 ? 11 : 8);
    check("config after refused frames", 27'(cfg_exp), 27'({global_quarter_select, pwm_en, interface_timeout_enable, multiplex_enable}));
    $display("test refused headers done");
    send_cmd(2'b11, 8, 8'h01);
    drain_en = 1'b0;
    send_cmd(2'b00, 8, 8'h00);
    $display("test buffer overflow done");
    @(negedge sys_clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge sys_clk_i);
    rst_n_i = 1'b1;
    cfg_exp = 4'h0;
    check("config after second reset", 27'h0, 27'({global_quarter_select, pwm_en, interface_timeout_enable, multiplex_enable}));
    check("overflow after reset", 27'h0, 27'(cap_ovf));
    send_cmd(2'b10, 9, 8'($urandom));
    $display("test second reset done");
    summarize();
  end
endmodule
